// File: verilog/rss_exec.sv
// Execute block for rotate-right-no-carry, set-all-ones and halt, with a Wishbone slave.
// Assumes a same-clock fetch stage, a data file with one-cycle read latency and an outside wake source.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module rss_exec
    import rss_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [WB_AW-1:0]     wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [WB_DW-1:0]     wb_dat_i,
    output logic      [WB_DW-1:0]     wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [OP_W-1:0]      opcode_i,
    input  wire logic                 opcode_valid_i,
    output logic                      opcode_ready_o,
    input  wire logic [ADDR_W-1:0]    index_base_i,
    output rss_file_req_s             file_req_o,
    input  wire logic [DATA_W-1:0]    file_rdata_i,
    input  wire logic                 wake_i,
    output logic                      sleep_o,
    output logic                      watchdog_clear_o,
    output logic                      instr_done_o
);

    rss_phase_e        phase_reg;
    rss_phase_e        phase_next;
    rss_op_e           op_reg;
    rss_op_e           op_dec;
    logic              dest_file_reg;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] acc_reg;
    logic [BANK_W-1:0] bank_select_reg;
    logic              ext_en_reg;
    logic              neg_reg;
    logic              zero_reg;
    logic              power_down_flag_reg;
    logic              timeout_flag_reg;
    logic              wdt_clr_reg;
    logic              done_reg;
    rss_file_req_s     file_req_reg;
    logic              ack_reg;
    logic [WB_DW-1:0]  rdata_reg;
    logic              wake_meta_reg;
    logic              wake_sync_reg;

    // Decode of the incoming word.
    wire               is_ror = (opcode_i[OP_W-1:ROR_TOP_LSB] == OP_ROR_TOP);
    wire               is_set = (opcode_i[OP_W-1:SET_TOP_LSB] == OP_SET_TOP);
    wire               is_halt = (opcode_i == OP_HALT);
    wire               take = opcode_valid_i && opcode_ready_o;
    wire [ADDR_W-1:0]  op_addr;
    wire [DATA_W-1:0]  rot_val = rss_ror(file_rdata_i);
    wire [1:0]         nz_val = rss_nz(result_reg);
    wire               in_process = (phase_reg == PH_PROCESS);
    wire               in_write = (phase_reg == PH_WRITE);
    wire               rd_start = take && (is_ror || is_set);
    wire               op_writes = (op_reg == OPK_ROR) || (op_reg == OPK_SET);
    wire               wr_start = in_process && dest_file_reg && op_writes;
    // The rotate result lands in result_reg at this same edge, so the write data comes from the rotator.
    wire [DATA_W-1:0]  wr_data = (op_reg == OPK_ROR) ? rot_val : result_reg;
    wire               set_load = (phase_reg == PH_READ) && (op_reg == OPK_SET);
    wire               ror_load = in_process && (op_reg == OPK_ROR);
    wire               ror_commit = in_write && (op_reg == OPK_ROR);
    wire               halt_clear = in_process && (op_reg == OPK_HALT);
    wire               halt_commit = in_write && (op_reg == OPK_HALT);

    assign op_dec = is_ror ? OPK_ROR : is_set ? OPK_SET : is_halt ? OPK_HALT : OPK_NONE;
    assign opcode_ready_o = (phase_reg == PH_DECODE);

    rss_addr_gen u_addr (
        .f_i          (opcode_i[F_MSB:0]),
        .access_i     (opcode_i[A_BIT]),
        .bank_i       (bank_select_reg),
        .ext_en_i     (ext_en_reg),
        .index_base_i (index_base_i),
        .addr_o       (op_addr),
        .indexed_o    ()
    );

    // Bus decode.
    wire               wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire               wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    wire               hit_ctrl = (wb_adr_i == REG_CTRL);
    wire               hit_bank = (wb_adr_i == REG_BANK);
    wire               hit_acc = (wb_adr_i == REG_ACC);
    wire               hit_status = (wb_adr_i == REG_STATUS);
    wire               wr_ctrl = wb_wr && hit_ctrl;
    wire               wr_bank = wb_wr && hit_bank;
    wire               wr_acc = wb_wr && hit_acc;
    wire [WB_DW-1:0]   status_word;
    wire [WB_DW-1:0]   rd_mux;

    assign status_word = (WB_DW'(zero_reg) << STAT_Z_BIT)
                       | (WB_DW'(neg_reg) << STAT_N_BIT)
                       | (WB_DW'(power_down_flag_reg) << STAT_PD_BIT)
                       | (WB_DW'(timeout_flag_reg) << STAT_TO_BIT)
                       | (WB_DW'(phase_reg == PH_HALT) << STAT_HALT_BIT);

    assign rd_mux = hit_ctrl   ? (WB_DW'(ext_en_reg) << CTRL_EXT_BIT) :
                    hit_bank   ? WB_DW'(bank_select_reg) :
                    hit_acc    ? WB_DW'(acc_reg) :
                    hit_status ? status_word : '0;

    assign wb_dat_o         = rdata_reg;
    assign wb_ack_o         = ack_reg;
    assign file_req_o       = file_req_reg;
    assign sleep_o          = (phase_reg == PH_HALT);
    assign watchdog_clear_o = wdt_clr_reg;
    assign instr_done_o     = done_reg;

    // Phase sequencing; an unknown opcode still spends the full cycle as a no-op.
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_DECODE: begin
                if (take) begin
                    phase_next = PH_READ;
                end
            end
            PH_READ: begin
                phase_next = PH_PROCESS;
            end
            PH_PROCESS: begin
                phase_next = PH_WRITE;
            end
            PH_WRITE: begin
                phase_next = (op_reg == OPK_HALT) ? PH_HALT : PH_DECODE;
            end
            PH_HALT: begin
                if (wake_sync_reg) begin
                    phase_next = PH_DECODE;
                end
            end
            default: begin
                phase_next = PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= PH_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // The wake source is not tied to this clock, so it passes two flops before the phase logic reads it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= wake_i;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // Instruction latch, taken in the decode phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= OPK_NONE;
        end else if (take) begin
            op_reg <= op_dec;
        end
    end

    // Set always writes the file, whatever bit 9 holds.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dest_file_reg <= 1'b0;
        end else if (take) begin
            dest_file_reg <= is_set || opcode_i[D_BIT];
        end
    end

    // Data file port: read in the read phase, write in the write phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_req_reg <= '0;
        end else begin
            file_req_reg.re <= rd_start;
            file_req_reg.we <= wr_start;
            if (take) begin
                file_req_reg.addr <= op_addr;
            end
            if (in_process) begin
                file_req_reg.wdata <= wr_data;
            end
        end
    end

    // Processing: the file read data is valid in the process phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_reg <= '0;
        end else if (set_load) begin
            result_reg <= ALL_ONES;
        end else if (ror_load) begin
            result_reg <= rot_val;
        end
    end

    // Accumulator; an instruction write wins over a bus write in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= ACC_RESET;
        end else if (ror_commit && !dest_file_reg) begin
            acc_reg <= result_reg;
        end else if (wr_acc) begin
            acc_reg <= wb_dat_i[DATA_W-1:0];
        end
    end

    // Only the rotate touches N and Z; set and halt leave them alone.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            neg_reg  <= 1'b0;
            zero_reg <= 1'b0;
        end else if (ror_commit) begin
            neg_reg  <= nz_val[1];
            zero_reg <= nz_val[0];
        end
    end

    // Halt effect on the watchdog, one pulse in the write phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clr_reg <= 1'b0;
        end else begin
            wdt_clr_reg <= halt_clear;
        end
    end

    // The power status bits move only at halt; wake causes that change them live outside this block.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_flag_reg <= PD_RESET;
            timeout_flag_reg    <= TO_RESET;
        end else if (halt_commit) begin
            power_down_flag_reg <= 1'b0;
            timeout_flag_reg    <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= in_write;
        end
    end

    // Software registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            ext_en_reg <= wb_dat_i[CTRL_EXT_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_select_reg <= BANK_RESET;
        end else if (wr_bank) begin
            bank_select_reg <= wb_dat_i[BANK_W-1:0];
        end
    end

    // Bus answer: one wait state, unmapped addresses read zero and ignore writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req;
        end
    end

    // Read data holds until the next request, so a slow master can still take it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (wb_req) begin
            rdata_reg <= rd_mux;
        end
    end

endmodule // rss_exec

// File: verilog/rss_pkg.sv
// Shared constants, types and helpers for the rotate/set/halt execute block.
// Assumes a single core clock and a same-clock fetch stage and data file.
package rss_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OP_W   = 16;
    localparam int WB_AW  = 8;
    localparam int WB_DW  = 32;

    // Opcode patterns and field positions.
    localparam logic [5:0]        OP_ROR_TOP = 6'h10;
    localparam logic [6:0]        OP_SET_TOP = 7'h34;
    localparam logic [OP_W-1:0]   OP_HALT    = 16'h0003;
    localparam int                ROR_TOP_LSB = 10;
    localparam int                SET_TOP_LSB = 9;
    localparam int                D_BIT       = 9;
    localparam int                A_BIT       = 8;
    localparam int                F_MSB       = 7;

    // Operand values and access bank layout.
    localparam logic [DATA_W-1:0] ALL_ONES      = 8'hFF;
    localparam logic [DATA_W-1:0] IDX_LIMIT     = 8'h5F;
    localparam logic [ADDR_W-1:0] ACC_LO_BASE   = 12'h000;
    localparam logic [ADDR_W-1:0] ACC_HI_BASE   = 12'hF00;

    // Register map, byte addresses.
    localparam logic [WB_AW-1:0]  REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0]  REG_BANK   = 8'h04;
    localparam logic [WB_AW-1:0]  REG_ACC    = 8'h08;
    localparam logic [WB_AW-1:0]  REG_STATUS = 8'h0C;

    // Field positions.
    localparam int CTRL_EXT_BIT  = 0;
    localparam int STAT_Z_BIT    = 0;
    localparam int STAT_N_BIT    = 1;
    localparam int STAT_PD_BIT   = 2;
    localparam int STAT_TO_BIT   = 3;
    localparam int STAT_HALT_BIT = 4;

    // Reset values.
    localparam logic              PD_RESET   = 1'b1;
    localparam logic              TO_RESET   = 1'b1;
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;

    typedef enum logic [1:0] {
        OPK_NONE,
        OPK_ROR,
        OPK_SET,
        OPK_HALT
    } rss_op_e;

    typedef enum logic [2:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE,
        PH_HALT
    } rss_phase_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } rss_file_req_s;

    function automatic logic [DATA_W-1:0] rss_ror(input logic [DATA_W-1:0] v);
        rss_ror = {v[0], v[DATA_W-1:1]};
    endfunction

    // Returns {negative, zero} for a result byte.
    function automatic logic [1:0] rss_nz(input logic [DATA_W-1:0] v);
        rss_nz = {v[DATA_W-1], (v == '0)};
    endfunction

endpackage

// File: verilog/rss_addr_gen.sv
// Data file address former for byte-oriented operands.
// Assumes the bank and index base inputs are stable while the operand is decoded.
`timescale 1ns/1ps
module rss_addr_gen
    import rss_pkg::*;
(
    input  wire logic [DATA_W-1:0] f_i,
    input  wire logic              access_i,
    input  wire logic [BANK_W-1:0] bank_i,
    input  wire logic              ext_en_i,
    input  wire logic [ADDR_W-1:0] index_base_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   indexed_o
);

    logic              low_half;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] bank_addr;
    logic [ADDR_W-1:0] idx_addr;

    assign low_half  = (f_i <= IDX_LIMIT);
    assign indexed_o = ext_en_i && !access_i && low_half;
    assign acc_addr  = low_half ? (ACC_LO_BASE | {4'h0, f_i}) : (ACC_HI_BASE | {4'h0, f_i});
    assign bank_addr = {bank_i, f_i};
    // Offset wraps inside the data space; the index base is the caller's concern.
    assign idx_addr  = index_base_i + {4'h0, f_i};
    assign addr_o    = indexed_o ? idx_addr : (access_i ? bank_addr : acc_addr);

endmodule // rss_addr_gen

// File: testbench/rss_exec_sva.sv
// Concurrent checks on the ports of the rotate/set/halt execute block.
// Assumes it is bound to rss_exec and shares its clock and synchronous reset.
`timescale 1ns/1ps
module rss_exec_sva
    import rss_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [OP_W-1:0]   opcode_i,
    input wire logic              opcode_valid_i,
    input wire logic              opcode_ready_o,
    input wire rss_file_req_s     file_req_o,
    input wire logic [DATA_W-1:0] file_rdata_i,
    input wire logic              sleep_o,
    input wire logic              watchdog_clear_o,
    input wire logic              instr_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic              take;
    logic              is_ror;
    logic              is_set;
    logic              is_halt;
    logic [DATA_W-1:0] rd_q;
    assign take    = opcode_valid_i && opcode_ready_o;
    assign is_ror  = opcode_i[OP_W-1:ROR_TOP_LSB] == OP_ROR_TOP;
    assign is_set  = opcode_i[OP_W-1:SET_TOP_LSB] == OP_SET_TOP;
    assign is_halt = opcode_i == OP_HALT;
    // The read reply lasts one cycle, so it is kept here for the write-back compare.
    always_ff @(posedge clk_i) rd_q <= file_rdata_i;
    sequence rd_wr_s;
        ##1 file_req_o.re ##2 file_req_o.we;
    endsequence
    sequence halt_steps_s;
        ##3 watchdog_clear_o ##1 sleep_o;
    endsequence
    ready_gap_a: assert property (take |=> !opcode_ready_o [*3]) else $error("ready back early");
    done_time_a: assert property (take |-> ##4 instr_done_o) else $error("done not at four cycles");
    ror_wback_a: assert property (take && is_ror && opcode_i[D_BIT] |-> rd_wr_s ##0
        (file_req_o.wdata == {rd_q[0], rd_q[DATA_W-1:1]})) else $error("rotate write-back wrong");
    ror_acc_a: assert property (take && is_ror && !opcode_i[D_BIT] |=> !file_req_o.we [*4])
        else $error("rotate to accumulator wrote file");
    set_write_a: assert property (take && is_set |-> rd_wr_s ##0 (file_req_o.wdata == ALL_ONES
        && file_req_o.addr == $past(file_req_o.addr, 2))) else $error("set write wrong");
    halt_idle_a: assert property (take && is_halt |=> (!file_req_o.re && !file_req_o.we) [*3])
        else $error("halt touched file");
    halt_wdt_a: assert property (take && is_halt |-> halt_steps_s) else $error("halt steps wrong");
    sleep_ready_a: assert property (sleep_o |-> !opcode_ready_o) else $error("ready while halted");
endmodule // rss_exec_sva

bind rss_exec rss_exec_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .opcode_i(opcode_i),
    .opcode_valid_i(opcode_valid_i), .opcode_ready_o(opcode_ready_o), .file_req_o(file_req_o),
    .file_rdata_i(file_rdata_i), .sleep_o(sleep_o), .watchdog_clear_o(watchdog_clear_o),
    .instr_done_o(instr_done_o));

// File: testbench/rss_file_model.sv
// Behavioural banked data file answering the execute block's requests.
// Assumes one-cycle read latency and the block's clock.
`timescale 1ns/1ps
module rss_file_model
    import rss_pkg::*;
(
    input  wire logic              clk_i,
    input  wire rss_file_req_s     file_req_i,
    output logic      [DATA_W-1:0] file_rdata_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    initial file_rdata_o = 8'hA5;
    // Outside a reply the port toggles, so stale data never passes for a fresh read.
    always @(posedge clk_i) begin
        if (file_req_i.re) begin
            file_rdata_o <= mem[file_req_i.addr];
        end else begin
            file_rdata_o <= ~file_rdata_o;
        end
        if (file_req_i.we) begin
            mem[file_req_i.addr] <= file_req_i.wdata;
        end
    end
endmodule // rss_file_model

// File: testbench/rss_exec_tb.sv
// Self-checking bench for the rotate/set/halt execute block.
// Assumes the data file model and the bound checker are compiled with it.
`timescale 1ns/1ps
module rss_exec_tb;
    import rss_pkg::*;
    logic                clk_i;
    logic                rst_i = 1'b1;
    logic                wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [WB_AW-1:0]    wb_adr = '0;
    logic [3:0]          wb_sel = 4'h0, sel_val = 4'hF;
    logic [WB_DW-1:0]    wb_dat = '0, wb_rdat, rd;
    logic [OP_W-1:0]     opcode = '0;
    logic                op_valid = 1'b0, op_ready, wake = 1'b0, sleep, wdt_clr, done;
    logic [ADDR_W-1:0]   index_base = 12'h200;
    logic [DATA_W-1:0]   file_rdata;
    rss_file_req_s       file_req;
    int                  failures = 0;
    int                  checks_done = 0;

    rss_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .opcode_i(opcode), .opcode_valid_i(op_valid), .opcode_ready_o(op_ready), .index_base_i(index_base),
        .file_req_o(file_req), .file_rdata_i(file_rdata), .wake_i(wake), .sleep_o(sleep),
        .watchdog_clear_o(wdt_clr), .instr_done_o(done));
    rss_file_model file_u (.clk_i(clk_i), .file_req_i(file_req), .file_rdata_o(file_rdata));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic mem_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        chk_word({24'h0, file_u.mem[a]}, {24'h0, e});
    endtask

    task automatic wb_cycle(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= sel_val;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_rdat;
        if (wb_ack !== 1'b1) begin
            failures++;
            $display("Error at %0t: no bus answer", $time);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        wb_sel <= 4'h0;
    endtask

    task automatic run_op(input logic [OP_W-1:0] op);
        int k;
        k = 0;
        @(posedge clk_i);
        op_valid <= 1'b1;
        opcode   <= op;
        do begin
            @(posedge clk_i);
            k++;
        end while (op_ready !== 1'b1 && k < 50);
        op_valid <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (done !== 1'b1 && k < 20);
        chk_word(k, 4);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        chk_word(rd, {28'h0, TO_RESET, PD_RESET, 2'b00});
        wb_cycle(1'b0, 8'h40, 32'h0, rd);
        chk_word(rd, 32'h0);
        wb_cycle(1'b1, REG_BANK, 32'h3, rd);
        file_u.mem[12'h320] = 8'hD7;
        file_u.mem[12'h010] = 8'hD7;
        file_u.mem[12'h310] = 8'h11;
        file_u.mem[12'hF80] = 8'h00;
        file_u.mem[12'h321] = 8'h5A;
        file_u.mem[12'h030] = 8'h00;
        run_op(16'h4320);
        mem_chk(12'h320, 8'hEB);
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        chk_word(rd, 32'h0000000E);
        run_op(16'h4010);
        wb_cycle(1'b0, REG_ACC, 32'h0, rd);
        chk_word(rd, 32'h000000EB);
        mem_chk(12'h010, 8'hD7);
        mem_chk(12'h310, 8'h11);
        sel_val = 4'h0;
        wb_cycle(1'b1, REG_ACC, 32'h55, rd);
        sel_val = 4'hF;
        wb_cycle(1'b0, REG_ACC, 32'h0, rd);
        chk_word(rd, 32'h000000EB);
        wb_cycle(1'b1, REG_ACC, 32'h55, rd);
        wb_cycle(1'b0, REG_ACC, 32'h0, rd);
        chk_word(rd, 32'h00000055);
        run_op(16'h4280);
        mem_chk(12'hF80, 8'h00);
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        chk_word(rd, 32'h0000000D);
        run_op(16'h6921);
        mem_chk(12'h321, 8'hFF);
        run_op(16'h6830);
        mem_chk(12'h030, 8'hFF);
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        chk_word(rd, 32'h0000000D);
        wb_cycle(1'b1, REG_CTRL, 32'h1, rd);
        file_u.mem[12'h25F] = 8'h00;
        file_u.mem[12'hF60] = 8'h00;
        file_u.mem[12'h205] = 8'h01;
        run_op(16'h685F);
        mem_chk(12'h25F, 8'hFF);
        run_op(16'h6860);
        mem_chk(12'hF60, 8'hFF);
        run_op(16'h4205);
        mem_chk(12'h205, 8'h80);
        run_op(16'hFFFF);
        run_op(16'h0003);
        chk_word({31'h0, sleep}, 32'h1);
        chk_word({31'h0, op_ready}, 32'h0);
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        chk_word(rd, 32'h0000001A);
        @(posedge clk_i);
        wake <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        wake <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_word({31'h0, op_ready}, 32'h1);
        run_op(16'h6830);
        give_verdict();
    end

    // About 120 cycles are needed; ten thousand leaves room without hiding a hang.
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule // rss_exec_tb
